// ### rtl/prc_pkg.sv
// Purpose: shared constants for the port role and output control registers
// Assumes: 8-bit registers, one clock at 10 MHz
// Notes: offsets are the register addresses seen by the port manager
`default_nettype none
package prc_pkg;
  // register addresses
  localparam logic [7:0] PRC_ADDR_STD_OUT = 8'h18;
  localparam logic [7:0] PRC_ADDR_PORT = 8'h19;
  localparam logic [7:0] PRC_ADDR_ROLE = 8'h1a;
  // standard_output_config fields
  localparam int PRC_STD_TRISTATE = 7;
  localparam int PRC_STD_DBG = 6;
  localparam int PRC_STD_LANE_HI = 3;
  localparam int PRC_STD_LANE_LO = 2;
  localparam int PRC_STD_FLIP = 0;
  localparam logic [7:0] PRC_STD_RST = 8'h40;
  localparam logic [7:0] PRC_STD_WMASK = 8'h8d;
  // port_control fields
  localparam int PRC_PORT_WDOG = 5;
  localparam int PRC_PORT_OWNER = 4;
  localparam int PRC_PORT_HOLD_HI = 3;
  localparam int PRC_PORT_HOLD_LO = 2;
  localparam int PRC_PORT_SELFTEST = 1;
  localparam int PRC_PORT_FLIP = 0;
  localparam logic [7:0] PRC_PORT_RST = 8'h00;
  localparam logic [7:0] PRC_PORT_WMASK = 8'h33;
  // role_control fields
  localparam int PRC_ROLE_DRP = 6;
  localparam int PRC_ROLE_RP_HI = 5;
  localparam int PRC_ROLE_RP_LO = 4;
  localparam int PRC_ROLE_CC2_HI = 3;
  localparam int PRC_ROLE_CC2_LO = 2;
  localparam int PRC_ROLE_CC1_HI = 1;
  localparam int PRC_ROLE_CC1_LO = 0;
  localparam logic [7:0] PRC_ROLE_RST_DB = 8'h0a;
  localparam logic [7:0] PRC_ROLE_RST_NORMAL = 8'h4a;
  localparam logic [7:0] PRC_ROLE_WMASK = 8'h7f;
  localparam logic [7:0] PRC_UNMAPPED_READ = 8'h00;
  // termination codes
  localparam logic [1:0] PRC_TERM_RA = 2'h0;
  localparam logic [1:0] PRC_TERM_RP = 2'h1;
  localparam logic [1:0] PRC_TERM_RD = 2'h2;
  localparam logic [1:0] PRC_TERM_OPEN = 2'h3;
  // pull-up current codes
  localparam logic [1:0] PRC_RP_DEFAULT = 2'h0;
  localparam logic [1:0] PRC_RP_1A5 = 2'h1;
  localparam logic [1:0] PRC_RP_3A0 = 2'h2;
  // timing
  localparam int PRC_CLK_HZ = 10_000_000;
  localparam int PRC_TOGGLE_HALF_US = 50;
  localparam int PRC_TOGGLE_CYCLES = PRC_TOGGLE_HALF_US * (PRC_CLK_HZ / 1_000_000);
  localparam logic [3:0] PRC_DB_SETTLE = 4'h4;
endpackage
`default_nettype wire

// ### rtl/prc_regs.sv
// Purpose: standard output, port control and role control registers with pin drive
// Assumes: register port fed by the serial front end on core_clk_i
// Notes: outputs are registered, so pins lag register writes by one cycle
`timescale 1ns/1ns
`default_nettype none
module prc_regs import prc_pkg::*; (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic sw_reset_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // pins and internal status
  input wire logic dead_battery_i,
  input wire logic cc_attach_i,
  input wire logic dbg_detect_i,
  input wire logic seek_connection_i,
  input wire logic vconn_en_i,
  input wire logic pd_msg_en_i,
  // standard outputs
  output logic dbg_accessory_indicator_o,
  output logic dbg_accessory_indicator_oe_o,
  output logic lane_select0_out_o,
  output logic lane_select0_out_oe_o,
  output logic lane_select1_out_o,
  output logic lane_select1_out_oe_o,
  output logic plug_flip_select_o,
  output logic plug_flip_select_oe_o,
  // port control effects
  output logic watchdog_en_o,
  output logic selftest_rx_discard_o,
  output logic vconn_to_cc1_o,
  output logic vconn_to_cc2_o,
  output logic bmc_monitor_cc2_o,
  // role effects
  output logic [1:0] line1_termination_o,
  output logic [1:0] line2_termination_o,
  output logic [1:0] pullup_current_level_o,
  output logic phy_power_down_o,
  output logic looking_for_conn_o
);
  logic [7:0] std_q;
  logic [7:0] port_q;
  logic [7:0] role_q;
  logic db_s1_q, db_s2_q, db_s3_q, db_filt_q;
  logic at_s1_q, at_s2_q, at_s3_q, at_filt_q;
  logic [3:0] settle_q;
  logic load_pend_q;
  logic db_latched_q;
  logic role_load;
  logic wr_std, wr_port, wr_role;
  logic owner;
  prc_toggle_if tif ();

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (wd & mask);
  endfunction

  // role reset value for a given strap level, shared by power-up and sw reset
  function automatic logic [7:0] role_rst(input logic db);
    role_rst = db ? PRC_ROLE_RST_DB : PRC_ROLE_RST_NORMAL;
  endfunction

  assign wr_std = reg_wr_i && (reg_addr_i == PRC_ADDR_STD_OUT);
  assign wr_port = reg_wr_i && (reg_addr_i == PRC_ADDR_PORT);
  assign wr_role = reg_wr_i && (reg_addr_i == PRC_ADDR_ROLE);
  assign owner = port_q[PRC_PORT_OWNER];
  assign role_load = load_pend_q && (settle_q == PRC_DB_SETTLE);

  // pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      db_s1_q <= 1'b0;
      db_s2_q <= 1'b0;
      db_s3_q <= 1'b0;
      db_filt_q <= 1'b0;
    end else begin
      db_s1_q <= dead_battery_i;
      db_s2_q <= db_s1_q;
      db_s3_q <= db_s2_q;
      if (db_s2_q == db_s3_q) begin
        db_filt_q <= db_s3_q;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      at_s1_q <= 1'b0;
      at_s2_q <= 1'b0;
      at_s3_q <= 1'b0;
      at_filt_q <= 1'b0;
    end else begin
      at_s1_q <= cc_attach_i;
      at_s2_q <= at_s1_q;
      at_s3_q <= at_s2_q;
      if (at_s2_q == at_s3_q) begin
        at_filt_q <= at_s3_q;
      end
    end
  end

  // power-up strap capture, taken once after release and never again
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      settle_q <= 4'h0;
      load_pend_q <= 1'b1;
      db_latched_q <= 1'b0;
    end else if (load_pend_q) begin
      if (role_load) begin
        load_pend_q <= 1'b0;
        db_latched_q <= db_filt_q;
      end else begin
        settle_q <= settle_q + 4'h1;
      end
    end
  end

  // standard_output_config
  always_ff @(posedge core_clk_i) begin
    if (srst_i || sw_reset_i) begin
      std_q <= PRC_STD_RST;
    end else if (wr_std) begin
      std_q <= merge(std_q, reg_wdata_i, PRC_STD_WMASK);
      if (owner) begin
        std_q[PRC_STD_DBG] <= reg_wdata_i[PRC_STD_DBG];
      end
    end
  end

  // port_control, clock hold field never stored
  always_ff @(posedge core_clk_i) begin
    if (srst_i || sw_reset_i) begin
      port_q <= PRC_PORT_RST;
    end else if (wr_port) begin
      port_q <= merge(port_q, reg_wdata_i, PRC_PORT_WMASK);
    end
  end

  // role_control: sw reset reuses the strap caught at power-up
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      role_q <= PRC_ROLE_RST_NORMAL;
    end else if (role_load) begin
      role_q <= role_rst(db_filt_q);
    end else if (sw_reset_i) begin
      role_q <= role_rst(db_latched_q);
    end else if (wr_role) begin
      role_q <= merge(role_q, reg_wdata_i, PRC_ROLE_WMASK);
    end
  end

  // read port
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= PRC_UNMAPPED_READ;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        PRC_ADDR_STD_OUT: reg_rdata_o <= std_q;
        PRC_ADDR_PORT: reg_rdata_o <= port_q;
        PRC_ADDR_ROLE: reg_rdata_o <= role_q;
        default: reg_rdata_o <= PRC_UNMAPPED_READ;
      endcase
    end
  end

  // toggle engine hookup
  assign tif.start = seek_connection_i;
  assign tif.dual_role_toggle = role_q[PRC_ROLE_DRP];
  assign tif.line1_termination = role_q[PRC_ROLE_CC1_HI:PRC_ROLE_CC1_LO];
  assign tif.line2_termination = role_q[PRC_ROLE_CC2_HI:PRC_ROLE_CC2_LO];
  assign tif.attach = at_filt_q;

  prc_toggle u_toggle (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .tif(tif)
  );

  // standard output pins; internal debug detect drives the indicator unless owned
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      dbg_accessory_indicator_o <= 1'b1;
      lane_select0_out_o <= 1'b0;
      lane_select1_out_o <= 1'b0;
      plug_flip_select_o <= 1'b0;
      dbg_accessory_indicator_oe_o <= 1'b0;
      lane_select0_out_oe_o <= 1'b0;
      lane_select1_out_oe_o <= 1'b0;
      plug_flip_select_oe_o <= 1'b0;
    end else begin
      dbg_accessory_indicator_o <= owner ? std_q[PRC_STD_DBG] : !dbg_detect_i;
      lane_select0_out_o <= std_q[PRC_STD_LANE_LO];
      lane_select1_out_o <= std_q[PRC_STD_LANE_HI];
      plug_flip_select_o <= std_q[PRC_STD_FLIP];
      dbg_accessory_indicator_oe_o <= !std_q[PRC_STD_TRISTATE];
      lane_select0_out_oe_o <= !std_q[PRC_STD_TRISTATE];
      lane_select1_out_oe_o <= !std_q[PRC_STD_TRISTATE];
      plug_flip_select_oe_o <= !std_q[PRC_STD_TRISTATE];
    end
  end

  // port control effects
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      watchdog_en_o <= 1'b0;
      selftest_rx_discard_o <= 1'b0;
      vconn_to_cc1_o <= 1'b0;
      vconn_to_cc2_o <= 1'b0;
      bmc_monitor_cc2_o <= 1'b0;
    end else begin
      watchdog_en_o <= port_q[PRC_PORT_WDOG];
      selftest_rx_discard_o <= port_q[PRC_PORT_SELFTEST];
      vconn_to_cc1_o <= vconn_en_i && port_q[PRC_PORT_FLIP];
      vconn_to_cc2_o <= vconn_en_i && !port_q[PRC_PORT_FLIP];
      bmc_monitor_cc2_o <= pd_msg_en_i && port_q[PRC_PORT_FLIP];
    end
  end

  // termination drive: toggle engine overrides the fixed fields while active
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      line1_termination_o <= PRC_TERM_OPEN;
      line2_termination_o <= PRC_TERM_OPEN;
      pullup_current_level_o <= PRC_RP_DEFAULT;
      phy_power_down_o <= 1'b0;
      looking_for_conn_o <= 1'b0;
    end else begin
      if (tif.active) begin
        line1_termination_o <= tif.cur_term;
        line2_termination_o <= tif.cur_term;
      end else begin
        line1_termination_o <= tif.line1_termination;
        line2_termination_o <= tif.line2_termination;
      end
      pullup_current_level_o <= role_q[PRC_ROLE_RP_HI:PRC_ROLE_RP_LO];
      phy_power_down_o <= !tif.dual_role_toggle && (tif.line1_termination == PRC_TERM_OPEN) &&
                          (tif.line2_termination == PRC_TERM_OPEN);
      looking_for_conn_o <= tif.looking;
    end
  end

  chk_tristate_all: assert property (@(posedge core_clk_i) disable iff (srst_i)
    std_q[PRC_STD_TRISTATE] |=> !dbg_accessory_indicator_oe_o && !lane_select0_out_oe_o &&
      !lane_select1_out_oe_o && !plug_flip_select_oe_o)
    else $error("standard outputs still driven in tri-state");

  chk_dbg_pin_follow: assert property (@(posedge core_clk_i) disable iff (srst_i)
    owner |=> dbg_accessory_indicator_o == $past(std_q[PRC_STD_DBG]))
    else $error("debug indicator pin does not follow register");

  chk_dbg_write_blocked: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (wr_std && !owner && !sw_reset_i) |=> $stable(std_q[PRC_STD_DBG]))
    else $error("debug bit written without ownership");

  chk_lane_select_map: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ##1 {lane_select1_out_o, lane_select0_out_o} ==
      $past(std_q[PRC_STD_LANE_HI:PRC_STD_LANE_LO]))
    else $error("lane select pins mismatch field");

  chk_clock_hold_zero: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_port |=> port_q[PRC_PORT_HOLD_HI:PRC_PORT_HOLD_LO] == 2'h0)
    else $error("clock hold field not zero");

  chk_port_sw_reset: assert property (@(posedge core_clk_i) disable iff (srst_i)
    sw_reset_i |=> port_q == PRC_PORT_RST)
    else $error("port control not cleared by software reset");

  chk_role_strap_load: assert property (@(posedge core_clk_i) disable iff (srst_i)
    role_load |=> role_q == ($past(db_filt_q) ? PRC_ROLE_RST_DB : PRC_ROLE_RST_NORMAL))
    else $error("role reset value wrong for strap");

  chk_phy_power_down: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (!tif.dual_role_toggle && tif.line1_termination == PRC_TERM_OPEN && tif.line2_termination == PRC_TERM_OPEN)
      |=> phy_power_down_o)
    else $error("phy not powered down with both lines open");

  chk_vconn_steer: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (vconn_en_i && port_q[PRC_PORT_FLIP]) |=> vconn_to_cc1_o && !vconn_to_cc2_o)
    else $error("vconn steered to wrong line");
endmodule
`default_nettype wire

// ### rtl/prc_toggle.sv
// Purpose: dual-role toggling engine, alternates Rp and Rd until attach
// Assumes: attach input already synchronised and filtered
// Notes: once resolved the termination is frozen until dual-role is cleared
`timescale 1ns/1ns
`default_nettype none
module prc_toggle import prc_pkg::*; (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // register bank side
  prc_toggle_if.eng tif
);
  typedef enum logic [1:0] {TG_IDLE, TG_SEEK, TG_DONE} prc_tg_state_t;
  localparam logic [15:0] HALF_LAST = 16'(PRC_TOGGLE_CYCLES - 1);

  prc_tg_state_t state_q;
  logic source_q;
  logic [15:0] cnt_q;
  logic terms_ok;

  assign terms_ok = (tif.line1_termination == tif.line2_termination) &&
                    (tif.line1_termination == PRC_TERM_RP || tif.line1_termination == PRC_TERM_RD);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q <= TG_IDLE;
      source_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        TG_IDLE: begin
          if (tif.start && tif.dual_role_toggle && terms_ok) begin
            state_q <= TG_SEEK;
            source_q <= (tif.line1_termination == PRC_TERM_RP);
            cnt_q <= 16'h0000;
          end
        end
        TG_SEEK: begin
          if (!tif.dual_role_toggle) begin
            state_q <= TG_IDLE;
          end else if (tif.attach) begin
            state_q <= TG_DONE;
          end else if (cnt_q == HALF_LAST) begin
            cnt_q <= 16'h0000;
            source_q <= !source_q;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        TG_DONE: begin
          // resolved role held whatever the line does
          if (!tif.dual_role_toggle) begin
            state_q <= TG_IDLE;
          end
        end
      endcase
    end
  end

  assign tif.active = (state_q != TG_IDLE);
  assign tif.looking = (state_q == TG_SEEK);
  assign tif.cur_term = source_q ? PRC_TERM_RP : PRC_TERM_RD;

  chk_seek_refused: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state_q == TG_IDLE && tif.start && !terms_ok) |=> (state_q == TG_IDLE))
    else $error("seek started with mixed terminations");

  chk_resolved_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state_q == TG_DONE && tif.dual_role_toggle) |=> (state_q == TG_DONE && $stable(source_q)))
    else $error("resolved termination changed");

  chk_seek_flag: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state_q == TG_SEEK && tif.dual_role_toggle && tif.attach) |=> !tif.looking)
    else $error("looking flag stayed up after attach");
endmodule
`default_nettype wire

// ### rtl/prc_toggle_if.sv
// Purpose: carrier between the register bank and the toggle engine
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ns
`default_nettype none
interface prc_toggle_if;
  logic start;
  logic dual_role_toggle;
  logic [1:0] line1_termination;
  logic [1:0] line2_termination;
  logic attach;
  logic active;
  logic looking;
  logic [1:0] cur_term;
  modport ctl (output start, dual_role_toggle, line1_termination, line2_termination, attach, input active, looking, cur_term);
  modport eng (input start, dual_role_toggle, line1_termination, line2_termination, attach, output active, looking, cur_term);
endinterface
`default_nettype wire

// ### sim/prc_host_model.sv
// Purpose: port manager side that drives the register byte port and commands
// Assumes: strobes are taken on the rising edge of core_clk_i
// Notes: idle address and data carry inverted junk so stale values never pass
`timescale 1ns/1ns
`default_nettype none
module prc_host_model (
  // clock
  input wire logic core_clk_i,
  // register port
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  // commands
  output logic seek_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    seek_o = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge core_clk_i);
    d = reg_rdata_i;
  endtask

  // caller programs a matching Rp or Rd pair first, except when a refusal is wanted
  task automatic seek();
    @(posedge core_clk_i);
    seek_o <= 1'b1;
    @(posedge core_clk_i);
    seek_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### sim/prc_regs_bench.sv
// Purpose: self-checking bench for the port role and output control registers
// Assumes: strap low at first power-up, high at the second
// Notes: pins() predicts terminations only while dual-role is off; the seek steps check them while seeking and once resolved
`timescale 1ns/1ns
`default_nettype none
module prc_regs_bench import prc_pkg::*;;
  logic core_clk_i = 1'b0;
  logic srst_i, sw_reset_i, dead_battery_i, cc_attach_i, dbg_detect_i, vconn_en_i, pd_msg_en_i;
  logic [7:0] addr, wdata, rdata, got;
  logic wr, rd, seek;
  logic dbg, dbg_oe, s0, s0_oe, s1, s1_oe, fl, fl_oe, wdg, st, v1, v2, bmc, pdn, look;
  logic [1:0] t1, t2, lvl;
  logic [3:0] hold;
  int mdl[3];
  int fail_count = 0;
  int n_checks = 0;
  int n;

  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end

  prc_host_model prc_host_model_inst (
    .core_clk_i(core_clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_rdata_i(rdata), .seek_o(seek)
  );

  prc_regs prc_regs_inst (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .sw_reset_i(sw_reset_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .dead_battery_i(dead_battery_i), .cc_attach_i(cc_attach_i),
    .dbg_detect_i(dbg_detect_i), .seek_connection_i(seek), .vconn_en_i(vconn_en_i),
    .pd_msg_en_i(pd_msg_en_i), .dbg_accessory_indicator_o(dbg),
    .dbg_accessory_indicator_oe_o(dbg_oe), .lane_select0_out_o(s0),
    .lane_select0_out_oe_o(s0_oe), .lane_select1_out_o(s1), .lane_select1_out_oe_o(s1_oe),
    .plug_flip_select_o(fl), .plug_flip_select_oe_o(fl_oe), .watchdog_en_o(wdg),
    .selftest_rx_discard_o(st), .vconn_to_cc1_o(v1), .vconn_to_cc2_o(v2),
    .bmc_monitor_cc2_o(bmc), .line1_termination_o(t1), .line2_termination_o(t2),
    .pullup_current_level_o(lvl), .phy_power_down_o(pdn), .looking_for_conn_o(look)
  );

  task automatic final_report();
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // what: 0 looking up, 1 line1 leaves Rp, 2 looking down
  task automatic await(input int lim, input int what);
    for (n = 0; n < lim; n++) begin
      if (what == 0 ? look === 1'b1 : what == 1 ? t1 !== 2'h1 : look === 1'b0) break;
      @(negedge core_clk_i);
    end
    if (n == lim) begin
      chk8("wait", 8'(what), 8'hff);
      final_report();
    end
  endtask

  task automatic mrst(input logic db);
    mdl[0] = 8'h40;
    mdl[1] = 8'h00;
    mdl[2] = db ? 8'h0a : 8'h4a;
  endtask

  task automatic swr();
    @(posedge core_clk_i);
    sw_reset_i <= 1'b1;
    @(posedge core_clk_i);
    sw_reset_i <= 1'b0;
  endtask

  task automatic wchk(input int i, input logic [7:0] d);
    logic [7:0] m;
    m = (i == 0) ? (8'h8d | (mdl[1][4] ? 8'h40 : 8'h00)) : (i == 1) ? 8'h33 : 8'h7f;
    mdl[i] = (mdl[i] & ~m) | (d & m);
    prc_host_model_inst.wr(8'h18 + 8'(i), d);
    prc_host_model_inst.rd(8'h18 + 8'(i), got);
    chk8("readback", 8'(mdl[i]), got);
  endtask

  task automatic rdall();
    for (int i = 0; i < 3; i++) begin
      prc_host_model_inst.rd(8'h18 + 8'(i), got);
      chk8("reg", 8'(mdl[i]), got);
    end
  endtask

  task automatic pins();
    logic [7:0] s, p, r;
    // look half a cycle away from the edge that launches the pins
    @(negedge core_clk_i);
    s = 8'(mdl[0]);
    p = 8'(mdl[1]);
    r = 8'(mdl[2]);
    chk8("oe", {4'h0, {4{~s[7]}}}, {4'h0, dbg_oe, s0_oe, s1_oe, fl_oe});
    if (!s[7])
      chk8("pins", {4'h0, (p[4] ? s[6] : ~dbg_detect_i), s[2], s[3], s[0]},
           {4'h0, dbg, s0, s1, fl});
    chk8("port", {6'h0, p[5], p[1]}, {6'h0, wdg, st});
    chk8("vconn", {6'h0, vconn_en_i & p[0], vconn_en_i & ~p[0]}, {6'h0, v1, v2});
    chk8("bmc", {7'h0, pd_msg_en_i & p[0]}, {7'h0, bmc});
    chk8("level", {6'h0, r[5:4]}, {6'h0, lvl});
    chk8("pdown", {7'h0, r[3:0] == 4'hf && !r[6]}, {7'h0, pdn});
    if (!r[6]) chk8("term", {4'h0, r[3:0]}, {4'h0, t2, t1});
  endtask

  initial begin
    srst_i = 1'b1;
    sw_reset_i = 1'b0;
    dead_battery_i = 1'b0;
    cc_attach_i = 1'b0;
    dbg_detect_i = 1'b0;
    vconn_en_i = 1'b1;
    pd_msg_en_i = 1'b1;
    void'($urandom(67806));
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    mrst(1'b0);
    rdall();
    pins();
    wchk(0, 8'h00);
    wchk(1, 8'hff);
    for (int k = 0; k < 4; k++) begin
      wchk(0, {k[0] & k[1], 1'b0, 2'h3, 2'(k), 1'b1, k[0]});
      wchk(2, {1'b1, 1'b0, 2'(k), 2'(k), 2'(k)});
      pins();
    end
    for (int j = 0; j < 40; j++) begin
      @(posedge core_clk_i);
      dbg_detect_i <= 1'($urandom);
      vconn_en_i <= 1'($urandom);
      pd_msg_en_i <= 1'($urandom);
      wchk($urandom % 3, 8'($urandom));
      pins();
    end
    prc_host_model_inst.wr(8'h1b, 8'hff);
    prc_host_model_inst.rd(8'h1b, got);
    chk8("unmapped", 8'h00, got);
    rdall();
    swr();
    mrst(1'b0);
    rdall();
    pins();
    // mixed pair must be refused
    wchk(2, 8'h49);
    prc_host_model_inst.seek();
    repeat (10) @(negedge core_clk_i);
    chk8("badseek", 8'h00, {7'h0, look});
    wchk(2, 8'h65);
    prc_host_model_inst.seek();
    await(10, 0);
    chk8("start", 8'h05, {4'h0, t2, t1});
    chk8("tlevel", 8'h02, {6'h0, lvl});
    await(600, 1);
    chk8("alt", 8'h0a, {4'h0, t2, t1});
    @(posedge core_clk_i);
    cc_attach_i <= 1'b1;
    await(20, 2);
    hold = {t2, t1};
    chk8("resolved", 8'h0a, {4'h0, hold});
    @(posedge core_clk_i);
    cc_attach_i <= 1'b0;
    repeat (1000) @(negedge core_clk_i);
    chk8("held", 8'h0a, {4'h0, t2, t1});
    chk8("rlevel", 8'h02, {6'h0, lvl});
    chk8("lookoff", 8'h00, {7'h0, look});
    // second power-up from the dead-battery supply
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    dead_battery_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    mrst(1'b1);
    rdall();
    dead_battery_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    rdall();
    swr();
    rdall();
    final_report();
  end
endmodule
`default_nettype wire
